// ### src/ssrw_params.svh
// constants for the supply supervisor reset and watchdog block
// assumes a 40 mhz clk_i timebase
`ifndef SSRW_PARAMS_SVH
`define SSRW_PARAMS_SVH
`define SSRW_CLK_HZ 40000000
`define SSRW_RESET_TIMEOUT_MS 140
`define SSRW_RESET_TIMEOUT_CYC ((`SSRW_RESET_TIMEOUT_MS * 64'd40000000 + 64'd999) / 64'd1000)
`define SSRW_WD_LONG_S 35
`define SSRW_WD_LONG_CYC (`SSRW_WD_LONG_S * 64'd40000000)
`define SSRW_WD_SHORT_CS 112
`define SSRW_WD_SHORT_CYC ((`SSRW_WD_SHORT_CS * 64'd40000000 + 64'd99) / 64'd100)
`define SSRW_CNT_W 32
`define SSRW_OUT_RST_VAL 1'b0
`define SSRW_PFO_RST_VAL 1'b0
`endif

// ### src/ssrw_pkg.sv
// types for the supply supervisor reset and watchdog block
// assumes ssrw_params.svh is included first
`include "ssrw_params.svh"
package ssrw_pkg;
  typedef logic [`SSRW_CNT_W-1:0] ssrw_cnt_t;
  typedef enum logic [1:0] {SSRW_WD_LONG, SSRW_WD_SHORT} ssrw_wd_mode_t;
  typedef struct packed {
    logic primary_ok;
    logic secondary_ok;
    logic aux_ok;
    logic manual_reset_n;
    logic watchdog_kick_in;
    logic watchdog_float;
    logic power_fail_ok;
  } ssrw_in_t;
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] s4;
    logic [1:0] s5;
    logic [1:0] s6;
    logic [1:0] s7;
  } ssrw_sync_t;
  typedef struct packed {
    ssrw_cnt_t pri_cnt;
    ssrw_cnt_t sec_cnt;
    ssrw_cnt_t wd_cnt;
    logic wd_fire;
    ssrw_wd_mode_t wd_mode;
    logic kick_prev;
    logic primary_reset_n;
    logic secondary_reset_n;
    logic power_fail_out_n;
  } ssrw_state_t;
endpackage

// ### src/ssrw_sync.sv
// two-flop synchronisers for the comparator and pin inputs
// assumes asynchronous inputs and an active-low synchronised reset
`timescale 1ns/1ps
module ssrw_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire ssrw_pkg::ssrw_in_t raw_i,
  output ssrw_pkg::ssrw_in_t sync_o
);
  ssrw_pkg::ssrw_sync_t q;
  ssrw_pkg::ssrw_sync_t d;
  always_comb begin
    d = q;
    if (en_i) begin
      d.s1 = {q.s1[0], raw_i.primary_ok};
      d.s2 = {q.s2[0], raw_i.secondary_ok};
      d.s3 = {q.s3[0], raw_i.aux_ok};
      d.s4 = {q.s4[0], raw_i.manual_reset_n};
      d.s5 = {q.s5[0], raw_i.watchdog_kick_in};
      d.s6 = {q.s6[0], raw_i.watchdog_float};
      d.s7 = {q.s7[0], raw_i.power_fail_ok};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign sync_o.primary_ok = q.s1[1];
  assign sync_o.secondary_ok = q.s2[1];
  assign sync_o.aux_ok = q.s3[1];
  assign sync_o.manual_reset_n = q.s4[1];
  assign sync_o.watchdog_kick_in = q.s5[1];
  assign sync_o.watchdog_float = q.s6[1];
  assign sync_o.power_fail_ok = q.s7[1];
endmodule

// ### src/ssrw_top.sv
// reset generation, watchdog and power-fail logic of a supply supervisor
// assumes analog comparators deliver levels; pad drive and pullups are outside
// Function
// - secondary reset low on either supply low or manual reset low
// - secondary reset held a full timeout after causes clear
// - secondary reset is active low, pad may be open-drain or push-pull
// - manual reset low forces the reset outputs
// - reset held while manual reset low and one timeout after
// - manual reset input pulled up outside so floating reads inactive
// - constant watchdog input beyond watchdog timeout gives a reset
// - watchdog counter cleared on any kick edge or asserted reset
// - long watchdog timeout after every reset event until first edge
// - short watchdog timeout after first edge; processor must kick faster
// - floating watchdog input disables the watchdog
// - auxiliary undervoltage asserts primary reset only
// - power-fail comparator result passed to power-fail logic
// - power-fail output follows comparator, no timeout on release
// - primary reset low on any cause, held a timeout after it clears
// - recurring undervoltage restarts the timeout count from zero
`timescale 1ns/1ps
`include "ssrw_params.svh"
module ssrw_top #(
  parameter logic [`SSRW_CNT_W-1:0] RESET_TIMEOUT_CYC = `SSRW_CNT_W'(`SSRW_RESET_TIMEOUT_CYC),
  parameter logic [`SSRW_CNT_W-1:0] WD_LONG_CYC = `SSRW_CNT_W'(`SSRW_WD_LONG_CYC),
  parameter logic [`SSRW_CNT_W-1:0] WD_SHORT_CYC = `SSRW_CNT_W'(`SSRW_WD_SHORT_CYC)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic primary_supply_ok_i,
  input wire logic secondary_supply_ok_i,
  input wire logic aux_undervoltage_in_ok_i,
  input wire logic manual_reset_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic watchdog_float_i,
  input wire logic power_fail_in_ok_i,
  output logic primary_reset_n_o,
  output logic secondary_reset_n_o,
  output logic power_fail_out_n_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  ssrw_pkg::ssrw_in_t raw;
  ssrw_pkg::ssrw_in_t sin;
  ssrw_pkg::ssrw_state_t q;
  ssrw_pkg::ssrw_state_t d;
  logic pri_cause;
  logic sec_cause;
  logic kick_edge;
  ssrw_pkg::ssrw_cnt_t wd_limit;

  function automatic ssrw_pkg::ssrw_cnt_t sat_inc(input ssrw_pkg::ssrw_cnt_t v);
    sat_inc = (v == '1) ? v : v + `SSRW_CNT_W'(1);
  endfunction

  function automatic ssrw_pkg::ssrw_cnt_t wd_limit_of(input ssrw_pkg::ssrw_wd_mode_t mode);
    case (mode)
      ssrw_pkg::SSRW_WD_LONG: begin
        wd_limit_of = WD_LONG_CYC;
      end
      ssrw_pkg::SSRW_WD_SHORT: begin
        wd_limit_of = WD_SHORT_CYC;
      end
      default: begin
        wd_limit_of = WD_LONG_CYC;
      end
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // manual reset pin assumed to carry an external pullup at the pad
  assign raw.primary_ok = primary_supply_ok_i;
  assign raw.secondary_ok = secondary_supply_ok_i;
  assign raw.aux_ok = aux_undervoltage_in_ok_i;
  assign raw.manual_reset_n = manual_reset_n_i;
  assign raw.watchdog_kick_in = watchdog_kick_in_i;
  assign raw.watchdog_float = watchdog_float_i;
  assign raw.power_fail_ok = power_fail_in_ok_i;

  ssrw_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(en_i),
    .raw_i(raw),
    .sync_o(sin)
  );

  always_comb begin
    sec_cause = !sin.primary_ok || !sin.secondary_ok || !sin.manual_reset_n;
    pri_cause = sec_cause || !sin.aux_ok || q.wd_fire;
    kick_edge = sin.watchdog_kick_in ^ q.kick_prev;
    wd_limit = wd_limit_of(q.wd_mode);
  end

  always_comb begin
    d = q;
    if (en_i) begin
      d.kick_prev = sin.watchdog_kick_in;
      // each timeout counter restarts from zero while its own cause is present; aux and watchdog restart the primary only
      if (sec_cause) begin
        d.sec_cnt = '0;
        d.secondary_reset_n = 1'b0;
      end else if (q.sec_cnt >= RESET_TIMEOUT_CYC) begin
        d.secondary_reset_n = 1'b1;
      end else begin
        d.sec_cnt = sat_inc(q.sec_cnt);
        d.secondary_reset_n = 1'b0;
      end
      if (pri_cause) begin
        d.pri_cnt = '0;
        d.primary_reset_n = 1'b0;
      end else if (q.pri_cnt >= RESET_TIMEOUT_CYC) begin
        d.primary_reset_n = 1'b1;
      end else begin
        d.pri_cnt = sat_inc(q.pri_cnt);
        d.primary_reset_n = 1'b0;
      end
      // expiry is a one-cycle cause; the primary timer then holds reset one timeout
      if (q.wd_fire) begin
        d.wd_fire = 1'b0;
      end
      if (!q.primary_reset_n || pri_cause || sin.watchdog_float) begin
        d.wd_cnt = '0;
        d.wd_mode = ssrw_pkg::SSRW_WD_LONG;
      end else if (kick_edge) begin
        d.wd_cnt = '0;
        d.wd_mode = ssrw_pkg::SSRW_WD_SHORT;
      end else if (q.wd_cnt >= wd_limit) begin
        d.wd_fire = 1'b1;
        d.wd_cnt = '0;
      end else begin
        d.wd_cnt = sat_inc(q.wd_cnt);
      end
      d.power_fail_out_n = sin.power_fail_ok;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.wd_mode <= ssrw_pkg::SSRW_WD_LONG;
      q.primary_reset_n <= `SSRW_OUT_RST_VAL;
      q.secondary_reset_n <= `SSRW_OUT_RST_VAL;
      q.power_fail_out_n <= `SSRW_PFO_RST_VAL;
    end else begin
      q <= d;
    end
  end

  // active-low level; pad variant chosen outside
  assign primary_reset_n_o = q.primary_reset_n;
  assign secondary_reset_n_o = q.secondary_reset_n;
  assign power_fail_out_n_o = q.power_fail_out_n;

  AST_SEC_ON_CAUSE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && sec_cause) |=> !secondary_reset_n_o)
    else $error("secondary reset not asserted on cause");
  AST_SEC_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && $fell(sec_cause)) |=> !secondary_reset_n_o [*8])
    else $error("secondary reset released early");
  AST_MR_PRI: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sin.manual_reset_n) |=> !primary_reset_n_o)
    else $error("primary reset not held during manual reset");
  AST_PRI_ON_AUX: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sin.aux_ok) |=> !primary_reset_n_o)
    else $error("primary reset not asserted on aux undervoltage");
  AST_WD_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !primary_reset_n_o) |=> (q.wd_cnt == '0))
    else $error("watchdog counter not cleared during reset");
  AST_WD_FLOAT: assert property (@(posedge clk_i) disable iff (!rst_n)
    (sin.watchdog_float && !q.wd_fire) |=> !q.wd_fire)
    else $error("watchdog fired while floating");
  AST_WD_SHORT: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && kick_edge && primary_reset_n_o && !pri_cause && !sin.watchdog_float)
      |=> (q.wd_mode == ssrw_pkg::SSRW_WD_SHORT))
    else $error("short watchdog mode not entered on kick");
  AST_WD_LONG: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && pri_cause) |=> (q.wd_mode == ssrw_pkg::SSRW_WD_LONG))
    else $error("long watchdog mode not restored on reset");
  AST_PFO: assert property (@(posedge clk_i) disable iff (!rst_n)
    en_i |=> (power_fail_out_n_o == $past(sin.power_fail_ok)))
    else $error("power-fail output does not follow comparator");
  AST_WD_FIRE_PRI: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && q.wd_fire) |=> !primary_reset_n_o)
    else $error("watchdog expiry did not assert primary reset");
  // reset hold timers
  AST_SEC_EARLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sec_cause && q.sec_cnt < RESET_TIMEOUT_CYC)
      |=> !secondary_reset_n_o)
    else $error("secondary reset released before timeout");
  AST_SEC_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sec_cause && q.sec_cnt >= RESET_TIMEOUT_CYC)
      |=> secondary_reset_n_o)
    else $error("secondary reset not released after timeout");
  AST_SEC_RESTART: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && sec_cause)
      |=> (q.sec_cnt == '0))
    else $error("secondary timer not restarted by cause");
  AST_SEC_MR: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sin.manual_reset_n)
      |=> !secondary_reset_n_o)
    else $error("secondary reset not held during manual reset");
  AST_SEC_SUPPLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && (!sin.primary_ok || !sin.secondary_ok))
      |=> !secondary_reset_n_o)
    else $error("secondary reset not asserted on supply low");
  AST_SEC_NO_AUX: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sec_cause && !sin.aux_ok && secondary_reset_n_o)
      |=> secondary_reset_n_o)
    else $error("secondary reset asserted by aux undervoltage");
  AST_SEC_NO_WD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sec_cause && q.wd_fire && secondary_reset_n_o)
      |=> secondary_reset_n_o)
    else $error("secondary reset asserted by watchdog");
  AST_SEC_CNT_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n)
    q.sec_cnt <= RESET_TIMEOUT_CYC)
    else $error("secondary timer ran past timeout");
  AST_PRI_EARLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !pri_cause && q.pri_cnt < RESET_TIMEOUT_CYC)
      |=> !primary_reset_n_o)
    else $error("primary reset released before timeout");
  AST_PRI_RELEASE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !pri_cause && q.pri_cnt >= RESET_TIMEOUT_CYC)
      |=> primary_reset_n_o)
    else $error("primary reset not released after timeout");
  AST_PRI_RESTART: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && pri_cause)
      |=> (q.pri_cnt == '0))
    else $error("primary timer not restarted by cause");
  AST_PRI_SUPPLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && (!sin.primary_ok || !sin.secondary_ok))
      |=> !primary_reset_n_o)
    else $error("primary reset not asserted on supply low");
  AST_PRI_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && $fell(pri_cause))
      |=> !primary_reset_n_o [*8])
    else $error("primary reset released early");
  AST_PRI_CNT_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n)
    q.pri_cnt <= RESET_TIMEOUT_CYC)
    else $error("primary timer ran past timeout");
  AST_PRI_COVERS_SEC: assert property (@(posedge clk_i) disable iff (!rst_n)
    !secondary_reset_n_o |-> !primary_reset_n_o)
    else $error("primary reset released while secondary held");
  // watchdog
  AST_WD_KICK_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && kick_edge)
      |=> (q.wd_cnt == '0))
    else $error("watchdog counter not cleared on kick");
  AST_WD_CAUSE_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && pri_cause)
      |=> (q.wd_cnt == '0))
    else $error("watchdog counter not cleared by reset cause");
  AST_WD_FLOAT_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && sin.watchdog_float)
      |=> (q.wd_cnt == '0))
    else $error("watchdog counting while floating");
  AST_WD_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && q.wd_fire)
      |=> !q.wd_fire)
    else $error("watchdog expiry longer than one cycle");
  AST_WD_EXPIRE: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && q.primary_reset_n && !pri_cause && !sin.watchdog_float && !kick_edge && q.wd_cnt >= wd_limit)
      |=> q.wd_fire)
    else $error("watchdog did not expire at limit");
  AST_WD_NO_EARLY: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !q.wd_fire && q.wd_cnt < wd_limit)
      |=> !q.wd_fire)
    else $error("watchdog expired before limit");
  AST_WD_STEP: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && q.primary_reset_n && !pri_cause && !sin.watchdog_float && !kick_edge && q.wd_cnt < wd_limit)
      |=> (q.wd_cnt == $past(q.wd_cnt) + `SSRW_CNT_W'(1)))
    else $error("watchdog counter did not advance");
  AST_WD_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n)
    q.wd_cnt <= wd_limit)
    else $error("watchdog counter above its limit");
  AST_WD_MODE_KEEP: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && q.wd_mode == ssrw_pkg::SSRW_WD_SHORT && q.primary_reset_n && !pri_cause && !sin.watchdog_float)
      |=> (q.wd_mode == ssrw_pkg::SSRW_WD_SHORT))
    else $error("short watchdog mode lost without reset");
  AST_WD_HELD_RESET: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !q.primary_reset_n)
      |=> (q.wd_mode == ssrw_pkg::SSRW_WD_LONG))
    else $error("long watchdog mode not held during reset");
  AST_KICK_TRACK: assert property (@(posedge clk_i) disable iff (!rst_n)
    en_i
      |=> (q.kick_prev == $past(sin.watchdog_kick_in)))
    else $error("kick history not tracking input");
  // power-fail output
  AST_PFO_LOW: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && !sin.power_fail_ok)
      |=> !power_fail_out_n_o)
    else $error("power-fail output not asserted");
  AST_PFO_FAST: assert property (@(posedge clk_i) disable iff (!rst_n)
    (en_i && sin.power_fail_ok)
      |=> power_fail_out_n_o)
    else $error("power-fail output release delayed");
endmodule

// ### testbench/ssrw_cpu_model.sv
// processor model: kicks the watchdog while out of reset
// assumes clk_i is the supervisor clock and reset_n_i its primary reset
`timescale 1ns/1ps
module ssrw_cpu_model #(
  parameter int KICK_GAP = 10
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic kick_en_i,
  output logic kick_o
);
  int cnt;
  initial begin
    kick_o = 1'b0;
    cnt = 0;
  end
  // toggles well inside the short timeout, only while reset is released
  always @(posedge clk_i) begin
    if (reset_n_i !== 1'b1 || kick_en_i !== 1'b1) begin
      cnt <= 0;
    end else if (cnt == KICK_GAP - 1) begin
      cnt <= 0;
      kick_o <= #2 ~kick_o;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### testbench/ssrw_top_test.sv
// self-checking bench for the supervisor reset and watchdog block
// assumes small timeouts: reset 20, long watchdog 200, short watchdog 50 cycles
`timescale 1ns/1ps
module ssrw_top_test;
  localparam int TO = 20;
  localparam int WL = 200;
  localparam int WS = 50;
  logic clk_i, nrst_i, pri_ok, sec_ok, aux_ok, mr_n, kick, wd_float, pf_ok, kick_en;
  logic primary_reset_n_n, secondary_reset_n_n, pfo_n, en;
  int miscompares, n_compared;
  ssrw_top #(.RESET_TIMEOUT_CYC(32'(TO)), .WD_LONG_CYC(32'(WL)), .WD_SHORT_CYC(32'(WS))) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .en_i(en), .primary_supply_ok_i(pri_ok),
    .secondary_supply_ok_i(sec_ok), .aux_undervoltage_in_ok_i(aux_ok), .manual_reset_n_i(mr_n),
    .watchdog_kick_in_i(kick), .watchdog_float_i(wd_float), .power_fail_in_ok_i(pf_ok),
    .primary_reset_n_o(primary_reset_n_n), .secondary_reset_n_o(secondary_reset_n_n), .power_fail_out_n_o(pfo_n));
  ssrw_cpu_model #(.KICK_GAP(10)) cpu_u (.clk_i(clk_i), .reset_n_i(primary_reset_n_n), .kick_en_i(kick_en), .kick_o(kick));
  task automatic stop_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  // cause just cleared: low until lo cycles, released by hi
  task automatic release_in(input int lo, input int hi, input logic sec_held);
    cyc(lo);
    chk(primary_reset_n_n, 1'b0, "primary released early");
    chk(secondary_reset_n_n, ~sec_held, "secondary wrong before timeout");
    cyc(hi - lo);
    chk(primary_reset_n_n, 1'b1, "primary not released");
    chk(secondary_reset_n_n, 1'b1, "secondary not released");
  endtask
  task automatic to_low(input int lim, output int n);
    n = 0;
    while (primary_reset_n_n !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic t_manual;
    mr_n = 1'b0;
    cyc(4);
    chk(primary_reset_n_n, 1'b0, "manual reset missed");
    chk(secondary_reset_n_n, 1'b0, "secondary missed manual");
    cyc(60);
    chk(secondary_reset_n_n, 1'b0, "reset dropped while held");
    mr_n = 1'b1;
    release_in(TO, TO + 8, 1'b1);
  endtask
  task automatic t_supply;
    for (int i = 0; i < 2; i++) begin
      pri_ok = (i != 0);
      sec_ok = (i == 0);
      cyc(4);
      chk(primary_reset_n_n, 1'b0, "primary missed supply");
      chk(secondary_reset_n_n, 1'b0, "secondary missed supply");
      pri_ok = 1'b1;
      sec_ok = 1'b1;
      release_in(TO, TO + 8, 1'b1);
    end
  endtask
  task automatic t_aux;
    aux_ok = 1'b0;
    cyc(4);
    chk(primary_reset_n_n, 1'b0, "aux undervoltage missed");
    chk(secondary_reset_n_n, 1'b1, "secondary hit by aux");
    aux_ok = 1'b1;
    cyc(12);
    aux_ok = 1'b0;
    cyc(2);
    aux_ok = 1'b1;
    release_in(TO, TO + 8, 1'b0);
  endtask
  task automatic t_pfo;
    en = 1'b0;
    pf_ok = 1'b0;
    cyc(6);
    chk(pfo_n, 1'b1, "power fail moved while disabled");
    en = 1'b1;
    cyc(4);
    chk(pfo_n, 1'b0, "power fail missed");
    chk(primary_reset_n_n, 1'b1, "power fail caused reset");
    pf_ok = 1'b1;
    cyc(4);
    chk(pfo_n, 1'b1, "power fail release late");
  endtask
  task automatic t_watchdog;
    int n;
    cyc(300);
    chk(primary_reset_n_n, 1'b1, "kicked watchdog fired");
    kick_en = 1'b0;
    to_low(100, n);
    chk(n >= WS - 10 && n <= WS + 6, 1'b1, "short timeout off");
    chk(secondary_reset_n_n, 1'b1, "secondary hit by watchdog");
    release_in(TO, TO + 8, 1'b0);
    to_low(WL + 40, n);
    chk(n >= WL - 10 && n <= WL + 6, 1'b1, "long timeout off");
    release_in(TO, TO + 8, 1'b0);
    wd_float = 1'b1;
    cyc(WL + 60);
    chk(primary_reset_n_n, 1'b1, "floating watchdog fired");
    kick_en = 1'b1;
    cyc(20);
    wd_float = 1'b0;
    cyc(100);
    chk(primary_reset_n_n, 1'b1, "watchdog fired after float");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    miscompares = 0;
    n_compared = 0;
    {nrst_i, wd_float} = 2'h0;
    {pri_ok, sec_ok, aux_ok, mr_n, pf_ok, kick_en} = 6'h3f;
    en = 1'b1;
    cyc(2);
    chk(primary_reset_n_n, 1'b0, "reset output high in reset");
    nrst_i = 1'b1;
    cyc(TO + 14);
    chk(primary_reset_n_n, 1'b1, "no release after reset");
    chk(pfo_n, 1'b1, "power fail stuck");
    t_manual;
    t_supply;
    t_aux;
    t_pfo;
    t_watchdog;
    stop_test;
  end
  initial begin
    #(5000 * 25);
    miscompares++;
    stop_test;
  end
endmodule
